//--- iu_consts.svh
`ifndef IU_CONSTS_SVH
`define IU_CONSTS_SVH

// Reset value of every integer register and flag.
`define IU_RST_WORD    32'h0000_0000
// Group code of the dual compute-block broadcast group.
`define IU_GRP_BCAST   6'h03
// Highest base index that circular or bit-reversed modes may use.
`define IU_CIRC_MAX_BASE 5'h03
// Top bit of a group code; groups at or above it are transfer-only.
`define IU_GRP_HI_BIT  5

`endif

//--- iu_pkg.sv
package iu_pkg;

    // Operations taken from the issue logic.
    typedef enum logic [3:0] {
        IU_ROR   = 4'h0,
        IU_ROL   = 4'h1,
        IU_ASHR  = 4'h2,
        IU_LSHR  = 4'h3,
        IU_ULOAD = 4'h4,
        IU_USTOR = 4'h5,
        IU_DLOAD = 4'h6,
        IU_DSTOR = 4'h7,
        IU_XFER  = 4'h8,
        IU_IMM   = 4'h9
    } iu_op_type;

    // Transfer widths in 32-bit words: one, two or four.
    typedef enum logic [1:0] {
        IU_SINGLE = 2'h0,
        IU_DOUBLE = 2'h1,
        IU_QUAD   = 2'h2
    } iu_size_type;

    // Addressing options of data register accesses.
    typedef enum logic [2:0] {
        IU_LINEAR = 3'h0,
        IU_CIRC   = 3'h1,
        IU_BITREV = 3'h2,
        IU_ALIGN  = 3'h3,
        IU_SALIGN = 3'h4
    } iu_opt_type;

    typedef enum logic [0:0] {
        IU_IDLE = 1'b0,
        IU_WAIT = 1'b1
    } iu_fsm_type;

    typedef struct packed {
        logic zero;
        logic neg;
        logic ovf;
        logic carry;
    } iu_flags_type;

    // One issued instruction.
    typedef struct packed {
        logic        valid;
        iu_op_type   op;
        logic        unit;
        iu_size_type size;
        logic        postMod;
        iu_opt_type  opt;
        logic [4:0]  dstIdx;
        logic [4:0]  srcIdx;
        logic [4:0]  baseIdx;
        logic [4:0]  offIdx;
        logic        useImm;
        logic        immExt;
        logic [31:0] imm;
        logic [5:0]  dstGrp;
        logic [5:0]  srcGrp;
        logic [31:0] circBase;
        logic [31:0] circLen;
        logic [127:0] data;
    } iu_req_type;

    // Command to data memory.
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [31:0] addr;
        iu_size_type size;
        iu_opt_type  opt;
        logic [127:0] wdata;
    } iu_mem_type;

    // Write into the chip-wide register groups.
    typedef struct packed {
        logic        valid;
        logic [5:0]  grp;
        logic [4:0]  idx;
        iu_size_type size;
        logic        both;
        logic [127:0] data;
    } iu_ureg_type;

    typedef struct packed {
        logic [1:0][31:0][31:0] file;
        iu_flags_type [1:0]     flags;
        iu_fsm_type             fsm;
        logic                   ready;
        logic                   xferExc;
        iu_mem_type             memCmd;
        iu_ureg_type            uregWr;
        iu_req_type             lastReq;
        logic [31:0]            lastSrc;
        logic [31:0]            lastBase;
        logic [31:0]            lastOff;
    } iu_state_type;

endpackage

//--- iu_core.sv
`include "iu_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module iu_core (
    // Clock and reset.
    input  wire logic           clock,
    input  wire logic           rstn,
    // Instruction issue.
    input  wire iu_pkg::iu_req_type issue,
    output logic                issueReady,
    // Data memory.
    output iu_pkg::iu_mem_type  memCmd,
    input  wire logic           memRvalid,
    input  wire logic [127:0]   memRdata,
    // Register groups and status.
    output iu_pkg::iu_ureg_type uregWr,
    output logic                xferException,
    output iu_pkg::iu_flags_type flagsFirst,
    output iu_pkg::iu_flags_type flagsSecond
);

    iu_pkg::iu_state_type st_reg;
    iu_pkg::iu_state_type st_next;
    logic         u;
    logic [31:0]  src;
    logic [31:0]  base;
    logic [31:0]  off;
    logic [31:0]  sum;
    logic [31:0]  res;
    logic [31:0]  rev;
    logic [31:0]  circEnd;
    logic         accept;

    // Bit-reversed view of the base, one wire per bit.
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi = gi + 1) begin : g_rev
            assign rev[gi] = base[31 - gi];
        end
    endgenerate

    // Whole next state; one-cycle pulses fall back to zero each cycle.
    always_comb begin
        st_next = st_reg;
        st_next.memCmd.valid = 1'b0;
        st_next.uregWr.valid = 1'b0;
        st_next.xferExc = 1'b0;
        st_next.lastReq = '0;
        u = issue.unit;
        src = st_reg.file[u][issue.srcIdx];
        base = st_reg.file[u][issue.baseIdx];
        off = issue.useImm ? issue.imm : st_reg.file[u][issue.offIdx];
        sum = base + off;
        circEnd = issue.circBase + issue.circLen;
        res = src;
        accept = issue.valid && st_reg.ready;
        if (accept) begin
            st_next.lastReq = issue;
            st_next.lastSrc = src;
            st_next.lastBase = base;
            st_next.lastOff = off;
        end
        case (st_reg.fsm)
            iu_pkg::IU_IDLE: begin
                if (accept) begin
                    case (issue.op)
                        iu_pkg::IU_ROR, iu_pkg::IU_ROL,
                        iu_pkg::IU_ASHR, iu_pkg::IU_LSHR: begin
                            case (issue.op)
                                iu_pkg::IU_ROR: begin
                                    res = {src[0], src[31:1]};
                                end
                                iu_pkg::IU_ROL: begin
                                    res = {src[30:0], src[31]};
                                end
                                iu_pkg::IU_ASHR: res = {src[31], src[31:1]};
                                default: res = {1'b0, src[31:1]};
                            endcase
                            st_next.file[u][issue.dstIdx] = res;
                            st_next.flags[u].zero = (res == `IU_RST_WORD);
                            st_next.flags[u].neg = res[31];
                            st_next.flags[u].ovf = 1'b0;
                            // Shifts hand the dropped bit to carry; rotates keep none.
                            st_next.flags[u].carry = issue.op[1] & src[0];
                        end
                        iu_pkg::IU_ULOAD, iu_pkg::IU_USTOR: begin
                            st_next.memCmd.valid = 1'b1;
                            st_next.memCmd.write = issue.op[0];
                            st_next.memCmd.size = issue.size;
                            st_next.memCmd.opt = iu_pkg::IU_LINEAR;
                            st_next.memCmd.wdata = issue.data;
                            if (issue.postMod) begin
                                st_next.memCmd.addr = base;
                                st_next.file[u][issue.baseIdx] = sum;
                            end else begin
                                st_next.memCmd.addr = sum;
                            end
                            if (!issue.op[0]) begin
                                st_next.fsm = iu_pkg::IU_WAIT;
                            end
                        end
                        iu_pkg::IU_DLOAD, iu_pkg::IU_DSTOR: begin
                            st_next.memCmd.valid = 1'b1;
                            st_next.memCmd.write = issue.op[0];
                            st_next.memCmd.size = issue.size;
                            st_next.memCmd.wdata = issue.data;
                            st_next.memCmd.opt = issue.opt;
                            // Alignment buffer modes exist only on quad loads.
                            if ((issue.opt == iu_pkg::IU_ALIGN ||
                                 issue.opt == iu_pkg::IU_SALIGN) &&
                                (issue.op[0] || issue.size != iu_pkg::IU_QUAD)) begin
                                st_next.memCmd.opt = iu_pkg::IU_LINEAR;
                            end
                            // Post-modify only; the base always moves.
                            st_next.memCmd.addr = base;
                            st_next.file[u][issue.baseIdx] = sum;
                            // Circular and bit-reversed trust a base index 0 to 3.
                            if (issue.opt == iu_pkg::IU_CIRC &&
                                sum >= circEnd) begin
                                st_next.file[u][issue.baseIdx] =
                                    sum - issue.circLen;
                            end
                            if (issue.opt == iu_pkg::IU_BITREV) begin
                                st_next.memCmd.addr = rev;
                            end
                            if (!issue.op[0]) begin
                                st_next.fsm = iu_pkg::IU_WAIT;
                            end
                        end
                        iu_pkg::IU_XFER: begin
                            if (issue.srcGrp == `IU_GRP_BCAST &&
                                issue.dstGrp != `IU_GRP_BCAST) begin
                                st_next.xferExc = 1'b1;
                            end else begin
                                st_next.uregWr.valid = 1'b1;
                                st_next.uregWr.grp = issue.dstGrp;
                                st_next.uregWr.idx = issue.dstIdx;
                                st_next.uregWr.size = issue.size;
                                st_next.uregWr.data = issue.data;
                                st_next.uregWr.both =
                                    (issue.srcGrp == `IU_GRP_BCAST);
                            end
                        end
                        iu_pkg::IU_IMM: begin
                            st_next.uregWr.valid = 1'b1;
                            st_next.uregWr.grp = {1'b0, issue.dstGrp[4:0]};
                            st_next.uregWr.idx = issue.dstIdx;
                            st_next.uregWr.size = iu_pkg::IU_SINGLE;
                            st_next.uregWr.both = 1'b0;
                            st_next.uregWr.data = {96'h0, issue.immExt ? issue.imm :
                                {{17{issue.imm[14]}}, issue.imm[14:0]}};
                        end
                        default: begin
                            st_next.fsm = iu_pkg::IU_IDLE;
                        end
                    endcase
                    // Loads target the lower groups only.
                    if (issue.op == iu_pkg::IU_ULOAD ||
                        issue.op == iu_pkg::IU_DLOAD) begin
                        st_next.uregWr.grp = {1'b0, issue.dstGrp[4:0]};
                        st_next.uregWr.idx = issue.dstIdx;
                        st_next.uregWr.size = issue.size;
                        st_next.uregWr.both = (issue.op == iu_pkg::IU_DLOAD) &&
                            (issue.dstGrp == `IU_GRP_BCAST);
                    end
                end
            end
            iu_pkg::IU_WAIT: begin
                // Flags are untouched while the load completes.
                if (memRvalid) begin
                    st_next.uregWr.valid = 1'b1;
                    st_next.uregWr.data = memRdata;
                    st_next.fsm = iu_pkg::IU_IDLE;
                end
            end
            default: begin
                st_next.fsm = iu_pkg::IU_IDLE;
            end
        endcase
        // Issue stalls only while a load waits for memory.
        st_next.ready = (st_next.fsm == iu_pkg::IU_IDLE);
    end

    // The only clocked process; reset clears everything but readiness.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st_reg <= '0;
            st_reg.ready <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign issueReady = st_reg.ready;
    assign memCmd = st_reg.memCmd;
    assign uregWr = st_reg.uregWr;
    assign xferException = st_reg.xferExc;
    assign flagsFirst = st_reg.flags[0];
    assign flagsSecond = st_reg.flags[1];

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    rot_right_a: assert property (st_reg.lastReq.valid &&
        st_reg.lastReq.op == iu_pkg::IU_ROR |->
        st_reg.file[st_reg.lastReq.unit][st_reg.lastReq.dstIdx] ==
        {st_reg.lastSrc[0], st_reg.lastSrc[31:1]})
        else $error("rotate right result wrong");
    rot_flags_a: assert property (st_reg.lastReq.valid &&
        st_reg.lastReq.op inside {iu_pkg::IU_ROR, iu_pkg::IU_ROL} |->
        !st_reg.flags[st_reg.lastReq.unit].ovf &&
        !st_reg.flags[st_reg.lastReq.unit].carry &&
        st_reg.flags[st_reg.lastReq.unit].zero == (st_reg.lastSrc == 32'h0))
        else $error("rotate flags wrong");
    ashr_sign_a: assert property (st_reg.lastReq.valid &&
        st_reg.lastReq.op == iu_pkg::IU_ASHR |->
        st_reg.flags[st_reg.lastReq.unit].neg == st_reg.lastSrc[31] &&
        st_reg.flags[st_reg.lastReq.unit].carry == st_reg.lastSrc[0])
        else $error("arithmetic shift wrong");
    lshr_carry_a: assert property (st_reg.lastReq.valid &&
        st_reg.lastReq.op == iu_pkg::IU_LSHR |->
        !st_reg.flags[st_reg.lastReq.unit].neg &&
        st_reg.flags[st_reg.lastReq.unit].carry == st_reg.lastSrc[0])
        else $error("logical shift wrong");
    mem_flags_a: assert property (issue.valid && issueReady &&
        issue.op inside {[iu_pkg::IU_ULOAD:iu_pkg::IU_DSTOR]} |=>
        $stable(st_reg.flags))
        else $error("memory access changed flags");
    pre_addr_a: assert property (st_reg.lastReq.valid &&
        st_reg.lastReq.op == iu_pkg::IU_USTOR && !st_reg.lastReq.postMod |->
        memCmd.valid && memCmd.addr == st_reg.lastBase + st_reg.lastOff)
        else $error("pre-modify address wrong");
    // Memory answers only loads, so an answer always meets a stalled issue.
    load_done_a: assert property (memRvalid && !issueReady |=>
        uregWr.valid && issueReady && uregWr.data == $past(memRdata))
        else $error("load data not written");
    xfer_exc_a: assert property (issue.valid && issueReady &&
        issue.op == iu_pkg::IU_XFER && issue.srcGrp == `IU_GRP_BCAST &&
        issue.dstGrp != `IU_GRP_BCAST |=> xferException && !uregWr.valid)
        else $error("broadcast exception missing");
    imm_sext_a: assert property (st_reg.lastReq.valid &&
        st_reg.lastReq.op == iu_pkg::IU_IMM && !st_reg.lastReq.immExt |->
        uregWr.data[31:15] == {17{st_reg.lastReq.imm[14]}})
        else $error("immediate not sign extended");

endmodule

`default_nettype wire

//--- iu_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

// Data memory stand-in that answers each load after a chosen lag.
module iu_mem_model (
    // Clock and reset.
    input  wire logic               clock,
    input  wire logic               rstn,
    // Commands from the integer unit, and the answer lag.
    input  wire iu_pkg::iu_mem_type memCmd,
    input  wire logic [3:0]         lag,
    // Load answers.
    output logic                    memRvalid,
    output logic [127:0]            memRdata
);
    logic [3:0]  waitCnt;
    logic        busy;
    logic [31:0] addr;

    // Word k of an answer is the load address plus k, low word first.
    // Between answers the bus shows the inverse of its last value, so
    // stale data can never pass for a fresh answer.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            busy      <= 1'b0;
            waitCnt   <= 4'h0;
            addr      <= 32'h0;
            memRvalid <= 1'b0;
            memRdata  <= 128'h0;
        end else begin
            memRvalid <= 1'b0;
            memRdata  <= ~memRdata;
            if (memCmd.valid && !memCmd.write) begin
                busy    <= 1'b1;
                waitCnt <= lag;
                addr    <= memCmd.addr;
            end else if (busy && waitCnt != 4'h0) begin
                waitCnt <= waitCnt - 4'h1;
            end else if (busy) begin
                busy      <= 1'b0;
                memRvalid <= 1'b1;
                memRdata  <= {addr + 32'h3, addr + 32'h2, addr + 32'h1, addr};
            end
        end
    end
endmodule

`default_nettype wire

//--- test_integer_unit_rotate_load_store.sv
`include "iu_consts.svh"
`timescale 1ns/1ps
`default_nettype none

`define CHK(what, exp, got) begin checked++; if ((got) !== (exp)) begin \
    n_errors++; $display("[FAIL] %s expected %h seen %h", what, exp, got); \
    end end

module test_integer_unit_rotate_load_store;
    logic                 clock;
    logic                 rstn;
    logic [3:0]           lag;
    iu_pkg::iu_req_type   issue;
    logic                 issueReady;
    iu_pkg::iu_mem_type   memCmd;
    logic                 memRvalid;
    logic [127:0]         memRdata;
    iu_pkg::iu_ureg_type  uregWr;
    logic                 xferException;
    iu_pkg::iu_flags_type flagsFirst;
    iu_pkg::iu_flags_type flagsSecond;
    int                   n_errors;
    int                   checked;

    iu_core dut (.clock(clock), .rstn(rstn), .issue(issue),
        .issueReady(issueReady), .memCmd(memCmd), .memRvalid(memRvalid),
        .memRdata(memRdata), .uregWr(uregWr), .xferException(xferException),
        .flagsFirst(flagsFirst), .flagsSecond(flagsSecond));

    iu_mem_model mem (.clock(clock), .rstn(rstn), .memCmd(memCmd),
        .lag(lag), .memRvalid(memRvalid), .memRdata(memRdata));

    // Free-running core clock at 100 MHz.
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    function automatic iu_pkg::iu_req_type mk(input iu_pkg::iu_op_type op,
                                              input logic unit);
        iu_pkg::iu_req_type r;
        r        = '0;
        r.op     = op;
        r.unit   = unit;
        r.useImm = 1'b1;
        return r;
    endfunction

    // Each request lets one edge pass first, so the valid level dropped by
    // the previous request and the new one never meet in one time step.
    // The request is taken at the second edge; results are settled on return.
    task automatic send(input iu_pkg::iu_req_type r);
        @(posedge clock);
        #1;
        r.valid = 1'b1;
        issue = r;
        @(posedge clock);
        #1;
        issue.valid = 1'b0;
    endtask

    // Kind of access comes from the request, never from what the unit shows.
    task automatic access(input iu_pkg::iu_req_type r, input logic [31:0] ea,
                          input iu_pkg::iu_opt_type eo);
        int           k;
        logic         isLoad;
        logic [127:0] ed;
        isLoad = (r.op == iu_pkg::IU_ULOAD) || (r.op == iu_pkg::IU_DLOAD);
        ed = {ea + 32'h3, ea + 32'h2, ea + 32'h1, ea};
        send(r);
        `CHK("memCmd.valid", 1'b1, memCmd.valid)
        `CHK("memCmd.addr", ea, memCmd.addr)
        `CHK("memCmd.opt", eo, memCmd.opt)
        `CHK("memCmd.size", r.size, memCmd.size)
        `CHK("memCmd.write", !isLoad, memCmd.write)
        if (!isLoad) begin
            `CHK("memCmd.wdata", r.data, memCmd.wdata)
        end else begin
            `CHK("issueReady", 1'b0, issueReady)
            k = 0;
            while (uregWr.valid !== 1'b1 && k < 20) begin
                @(posedge clock);
                #1;
                k++;
            end
            `CHK("uregWr.valid", 1'b1, uregWr.valid)
            `CHK("uregWr.grp.top", 1'b0, uregWr.grp[5])
            `CHK("uregWr.grp", {1'b0, r.dstGrp[4:0]}, uregWr.grp)
            `CHK("uregWr.size", r.size, uregWr.size)
            `CHK("issueReady again", 1'b1, issueReady)
            if (r.size == iu_pkg::IU_QUAD) begin
                `CHK("uregWr.data", ed, uregWr.data)
            end else begin
                `CHK("uregWr.data0", ea, uregWr.data[31:0])
            end
        end
    endtask

    // A post-modify store from a register still at zero loads it.
    task automatic set_reg(input logic u, input logic [4:0] i,
                           input logic [31:0] v);
        iu_pkg::iu_req_type r;
        r = mk(iu_pkg::IU_USTOR, u);
        r.postMod = 1'b1;
        r.baseIdx = i;
        r.imm = v;
        access(r, 32'h0, iu_pkg::IU_LINEAR);
    endtask

    // A pre-modify store with zero offset shows a register on the address.
    task automatic chk_reg(input logic u, input logic [4:0] i,
                           input logic [31:0] v);
        iu_pkg::iu_req_type r;
        r = mk(iu_pkg::IU_USTOR, u);
        r.baseIdx = i;
        access(r, v, iu_pkg::IU_LINEAR);
    endtask

    task automatic alu(input iu_pkg::iu_op_type op, input logic [4:0] s,
                       input logic [4:0] d, input logic [3:0] ef,
                       input logic [31:0] ev);
        iu_pkg::iu_req_type r;
        r = mk(op, 1'b1);
        r.srcIdx = s;
        r.dstIdx = d;
        send(r);
        `CHK("flagsSecond", ef, flagsSecond)
        chk_reg(1'b1, d, ev);
        `CHK("flagsSecond kept", ef, flagsSecond)
    endtask

    task automatic t_rot_shift();
        set_reg(1'b1, 5'h01, 32'h8000_0005);
        set_reg(1'b1, 5'h06, 32'hffff_ffff);
        set_reg(1'b1, 5'h09, 32'h8600_0000);
        alu(iu_pkg::IU_ROR, 5'h01, 5'h02, 4'h4, 32'hc000_0002);
        alu(iu_pkg::IU_ROL, 5'h01, 5'h03, 4'h0, 32'h0000_000b);
        alu(iu_pkg::IU_ROR, 5'h04, 5'h05, 4'h8, 32'h0000_0000);
        alu(iu_pkg::IU_ASHR, 5'h06, 5'h07, 4'h5, 32'hffff_ffff);
        alu(iu_pkg::IU_LSHR, 5'h06, 5'h08, 4'h1, 32'h7fff_ffff);
        alu(iu_pkg::IU_ASHR, 5'h09, 5'h0a, 4'h4, 32'hc300_0000);
        alu(iu_pkg::IU_LSHR, 5'h09, 5'h0b, 4'h0, 32'h4300_0000);
        `CHK("flagsFirst", 4'h0, flagsFirst)
    endtask

    task automatic t_addressing();
        iu_pkg::iu_req_type r;
        lag = 4'h5;
        set_reg(1'b0, 5'h00, 32'd10);
        r = mk(iu_pkg::IU_DLOAD, 1'b0);
        r.baseIdx = 5'h00;
        r.opt = iu_pkg::IU_CIRC;
        r.imm = 32'd4;
        r.circLen = 32'd12;
        access(r, 32'd10, iu_pkg::IU_CIRC);
        chk_reg(1'b0, 5'h00, 32'd2);
        set_reg(1'b0, 5'h01, 32'h1);
        r = mk(iu_pkg::IU_DLOAD, 1'b0);
        r.opt = iu_pkg::IU_BITREV;
        r.baseIdx = 5'h01;
        r.imm = 32'h1;
        access(r, 32'h8000_0000, iu_pkg::IU_BITREV);
        r = mk(iu_pkg::IU_DSTOR, 1'b0);
        r.baseIdx = 5'h01;
        r.imm = 32'h3;
        r.data = 128'h5a5a;
        access(r, 32'h2, iu_pkg::IU_LINEAR);
        chk_reg(1'b0, 5'h01, 32'h5);
        lag = 4'h0;
        r = mk(iu_pkg::IU_ULOAD, 1'b0);
        r.size = iu_pkg::IU_QUAD;
        r.baseIdx = 5'h03;
        r.imm = 32'h8;
        r.dstGrp = 6'h28;
        access(r, 32'h8, iu_pkg::IU_LINEAR);
        chk_reg(1'b0, 5'h03, 32'h0);
        r = mk(iu_pkg::IU_DLOAD, 1'b0);
        r.size = iu_pkg::IU_QUAD;
        r.baseIdx = 5'h04;
        r.opt = iu_pkg::IU_ALIGN;
        access(r, 32'h0, iu_pkg::IU_ALIGN);
        r.opt = iu_pkg::IU_SALIGN;
        access(r, 32'h0, iu_pkg::IU_SALIGN);
        r.size = iu_pkg::IU_SINGLE;
        access(r, 32'h0, iu_pkg::IU_LINEAR);
    endtask

    // Immediate moves carry a five-bit group and are always single words.
    task automatic xfer(input iu_pkg::iu_req_type r, input logic exc,
                        input logic [31:0] ew, input logic bc);
        logic [5:0]          eg;
        iu_pkg::iu_size_type es;
        eg = r.dstGrp;
        es = r.size;
        if (r.op == iu_pkg::IU_IMM) begin
            eg = {1'b0, r.dstGrp[4:0]};
            es = iu_pkg::IU_SINGLE;
        end
        send(r);
        `CHK("xferException", exc, xferException)
        `CHK("uregWr.valid", !exc, uregWr.valid)
        if (!exc) begin
            `CHK("uregWr.data", ew, uregWr.data[31:0])
            `CHK("uregWr.grp", eg, uregWr.grp)
            `CHK("uregWr.idx", r.dstIdx, uregWr.idx)
            `CHK("uregWr.size", es, uregWr.size)
            `CHK("uregWr.both", bc, uregWr.both)
        end
    endtask

    task automatic t_transfers();
        iu_pkg::iu_req_type r;
        r = mk(iu_pkg::IU_IMM, 1'b0);
        r.dstGrp = 6'h05;
        r.dstIdx = 5'h07;
        r.imm = 32'h0000_4000;
        xfer(r, 1'b0, 32'hffff_c000, 1'b0);
        r.imm = 32'h0000_3fff;
        xfer(r, 1'b0, 32'h0000_3fff, 1'b0);
        r.immExt = 1'b1;
        r.imm = 32'h1234_5678;
        xfer(r, 1'b0, 32'h1234_5678, 1'b0);
        r = mk(iu_pkg::IU_XFER, 1'b1);
        r.srcGrp = `IU_GRP_BCAST;
        r.dstGrp = 6'h05;
        xfer(r, 1'b1, 32'h0, 1'b0);
        r.dstGrp = `IU_GRP_BCAST;
        r.size = iu_pkg::IU_DOUBLE;
        r.data = 128'h0a0b;
        xfer(r, 1'b0, 32'h0a0b, 1'b1);
        for (int u = 0; u < 2; u++) begin
            r = mk(iu_pkg::IU_XFER, u[0]);
            r.srcGrp = 6'h30;
            r.dstGrp = 6'h2a;
            r.dstIdx = 5'h1f;
            r.size = iu_pkg::IU_QUAD;
            r.data = 128'h4444_3333_2222_1111;
            xfer(r, 1'b0, 32'h2222_1111, 1'b0);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Cuts a hang short; the whole sequence needs well under 1000 cycles.
    initial begin
        #50000;
        n_errors++;
        tally_and_finish();
    end

    // Main sequence.
    initial begin
        n_errors = 0;
        checked = 0;
        rstn = 1'b0;
        lag = 4'h0;
        issue = '0;
        repeat (2) @(posedge clock);
        #1;
        rstn = 1'b1;
        `CHK("issueReady", 1'b1, issueReady)
        `CHK("flagsFirst", 4'h0, flagsFirst)
        t_rot_shift();
        t_addressing();
        t_transfers();
        tally_and_finish();
    end
endmodule

`default_nettype wire
